// file: src/hes_regs.vh
// Purpose: Offsets, field positions and reset values of the host event block
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Definitions only
`ifndef HES_REGS_VH
`define HES_REGS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define HES_OFS_STATUS0      24'h00FCCE
`define HES_OFS_IRQ_EN0      24'h00FCD0
`define HES_OFS_WAKE_CTL1    24'h00FCD4
`define HES_OFS_RST_EVT      24'h00FCD6

// ****************************************************************
// Field positions
// ****************************************************************
`define HES_BIT_RI1          0
`define HES_BIT_RI2          1
`define HES_BIT_RING         3
`define HES_BIT_SOFT         6
`define HES_BIT_MODIRQ       7
`define HES_BIT_CAPT_MODE    0
`define HES_BIT_RING_MODE    1
`define HES_BIT_RST_STS      0
`define HES_BIT_RST_EN       1

// ****************************************************************
// Masks and reset values
// ****************************************************************
`define HES_IMPL_MASK        8'hCB
`define HES_RST_STATUS0      8'h00
`define HES_RST_IRQ_EN0      8'h00
`define HES_RST_WAKE_CTL1    2'h0
`define HES_RST_BYTE         8'h00

`endif

// file: src/hes_edge.v
// Purpose: Rising and falling edge detect on a group of synchronous inputs
// Assumes: Inputs already synchronous to core_clk
// Notes:   First sample after reset is taken as low
`default_nettype none

module hes_edge #(
    parameter W = 3
) (
    input  wire         core_clk,
    input  wire         rst_n,
    input  wire         ce,
    input  wire [W-1:0] sig,
    output wire [W-1:0] rise,
    output wire [W-1:0] fall
);

    // ****************************************************************
    // Previous sample
    // ****************************************************************
    reg [W-1:0] prev_ff;

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_ff <= {W{1'b0}};
        else if (ce)
            prev_ff <= sig;
    end

    assign rise = sig & ~prev_ff & {W{ce}};
    assign fall = ~sig & prev_ff & {W{ce}};

endmodule

`default_nettype wire

// file: src/hes_event_bit.v
// Purpose: One sticky event flag, cleared by a one written to it
// Assumes: Set, clear and sync reset are one-cycle pulses
// Notes:   Sync reset beats set, set beats software clear
`default_nettype none

module hes_event_bit (
    input  wire core_clk,
    input  wire rst_n,
    input  wire ce,
    input  wire sync_clr,
    input  wire set,
    input  wire w1c,
    output wire q
);

    // ****************************************************************
    // Flag
    // ****************************************************************
    reg flag_ff;

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_ff <= 1'b0;
        else if (ce)
        begin
            if (sync_clr)
                flag_ff <= 1'b0;
            else if (set)
                flag_ff <= 1'b1;
            else if (w1c)
                flag_ff <= 1'b0;
        end
    end

    assign q = flag_ff;

endmodule

`default_nettype wire

// file: src/hes_host_event_irq.v
// Purpose: Host event status latch and core interrupt enable logic
// Assumes: All inputs synchronous to core_clk, strobes one cycle long
// Notes:   Read data stand in the cycle after the read strobe only
//
// Notes on behaviour
// - Wake status event also sets event status
// - Event status and wake status clear independently
// - Power-up or host software reset zeroes status
// - Writing one clears status bit, zero ignored
// - Ring bit set per selected ring mode
// - Mode clear: wake bit 6 rise sets bit
// - Mode set: wake bit1 one-write sets bit
// - Module IRQ bit sticky until software clears
// - Warm reset zeroes interrupt enable register
// - Enabled set status drives level core interrupt
// - Interrupt drops on status or enable clear
// - Merge wake and PM events onto request
// - Host reset falling edge flags firmware event
//
// Added by the designer: the plain strobed port.
`default_nettype none
`include "hes_regs.vh"

module hes_host_event_irq #(
    parameter AW  = 24,
    parameter PMW = 4
) (
    input  wire           core_clk,
    input  wire           rst_n,
    input  wire           ce,
    input  wire           host_sw_reset,
    input  wire           warm_reset,
    input  wire [AW-1:0]  reg_addr,
    input  wire [7:0]     reg_wdata,
    input  wire           reg_wr,
    input  wire           reg_rd,
    output reg  [7:0]     reg_rdata,
    input  wire           ri1_event,
    input  wire           ri2_event,
    input  wire           module_irq_event,
    input  wire           ring_in,
    input  wire [7:0]     wake_status0,
    input  wire           wake_sts0_bit1_wr,
    input  wire           host_reset_input,
    input  wire [PMW-1:0] pm_event_in,
    output reg            core_irq,
    output reg            power_wake_request
);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire sel_status;
    wire sel_irq_en;
    wire sel_ctl;
    wire sel_rst;

    assign sel_status = (reg_addr == `HES_OFS_STATUS0);
    assign sel_irq_en = (reg_addr == `HES_OFS_IRQ_EN0);
    assign sel_ctl    = (reg_addr == `HES_OFS_WAKE_CTL1);
    assign sel_rst    = (reg_addr == `HES_OFS_RST_EVT);

    // ****************************************************************
    // Write strobes
    // ****************************************************************
    wire       wr_status;
    wire       wr_irq_en;
    wire       wr_ctl;
    wire       wr_rst;
    wire [7:0] w1c_vec;
    wire       rst_w1c;

    assign wr_status = reg_wr & sel_status;
    assign wr_irq_en = reg_wr & sel_irq_en;
    assign wr_ctl    = reg_wr & sel_ctl;
    assign wr_rst    = reg_wr & sel_rst;
    assign w1c_vec   = wr_status ? reg_wdata : 8'h00;
    assign rst_w1c   = wr_rst & reg_wdata[`HES_BIT_RST_STS];

    // ****************************************************************
    // Control registers
    // ****************************************************************
    reg [1:0] ctl_ff;
    reg [1:0] nxt_ctl;
    reg [7:0] irq_en_ff;
    reg [7:0] nxt_irq_en;
    reg       rst_en_ff;
    reg       nxt_rst_en;

    always @*
    begin
        nxt_ctl = ctl_ff;
        if (wr_ctl)
            nxt_ctl = reg_wdata[1:0];
    end

    always @*
    begin
        nxt_irq_en = irq_en_ff;
        if (warm_reset)
            nxt_irq_en = `HES_RST_IRQ_EN0;
        else if (wr_irq_en)
            nxt_irq_en = reg_wdata & `HES_IMPL_MASK;
    end

    always @*
    begin
        nxt_rst_en = rst_en_ff;
        if (warm_reset)
            nxt_rst_en = 1'b0;
        else if (wr_rst)
            nxt_rst_en = reg_wdata[`HES_BIT_RST_EN];
    end

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_ff    <= `HES_RST_WAKE_CTL1;
            irq_en_ff <= `HES_RST_IRQ_EN0;
            rst_en_ff <= 1'b0;
        end
        else if (ce)
        begin
            ctl_ff    <= nxt_ctl;
            irq_en_ff <= nxt_irq_en;
            rst_en_ff <= nxt_rst_en;
        end
    end

    wire capt_mode;
    wire ring_mode;

    assign capt_mode = ctl_ff[`HES_BIT_CAPT_MODE];
    assign ring_mode = ctl_ff[`HES_BIT_RING_MODE];

    // ****************************************************************
    // Edge detection
    // ****************************************************************
    wire [2:0] edge_rise;
    wire [2:0] edge_fall;

    hes_edge #(
        .W (3)
    ) u_edge (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .sig      ({host_reset_input, ring_in, wake_status0[`HES_BIT_SOFT]}),
        .rise     (edge_rise),
        .fall     (edge_fall)
    );

    // ****************************************************************
    // Event set sources
    // ****************************************************************
    wire       ring_rise;
    wire       ring_fall;
    wire       soft_rise;
    wire       host_rst_fall;
    wire       ring_hit;
    wire       soft_hit;
    wire [7:0] set_vec;

    assign ring_rise     = edge_rise[1];
    assign ring_fall     = edge_fall[1];
    assign soft_rise     = edge_rise[0];
    assign host_rst_fall = edge_fall[2];

    assign ring_hit = ring_mode ? ring_fall : ring_rise;
    assign soft_hit = capt_mode ? wake_sts0_bit1_wr : soft_rise;

    // Same set pulses feed wake status elsewhere; clears stay separate
    assign set_vec[`HES_BIT_RI1]    = ri1_event;
    assign set_vec[`HES_BIT_RI2]    = ri2_event;
    assign set_vec[2]               = 1'b0;
    assign set_vec[`HES_BIT_RING]   = ring_hit;
    assign set_vec[5:4]             = 2'b00;
    assign set_vec[`HES_BIT_SOFT]   = soft_hit;
    assign set_vec[`HES_BIT_MODIRQ] = module_irq_event;

    // ****************************************************************
    // Status flags
    // ****************************************************************
    localparam [7:0] IMPL_MASK = `HES_IMPL_MASK;

    wire [7:0]  status_q;
    wire        sts_clr;

    assign sts_clr = host_sw_reset;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_sts
            if (IMPL_MASK[gi])
            begin : g_impl
                hes_event_bit u_bit (
                    .core_clk (core_clk),
                    .rst_n    (rst_n),
                    .ce       (ce),
                    .sync_clr (sts_clr),
                    .set      (set_vec[gi]),
                    .w1c      (w1c_vec[gi]),
                    .q        (status_q[gi])
                );
            end
            else
            begin : g_rsvd
                assign status_q[gi] = 1'b0;
            end
        end
    endgenerate

    // ****************************************************************
    // Host reset falling edge event
    // ****************************************************************
    wire rst_sts_q;

    hes_event_bit u_rst_evt (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .sync_clr (1'b0),
        .set      (host_rst_fall),
        .w1c      (rst_w1c),
        .q        (rst_sts_q)
    );

    // ****************************************************************
    // Interrupt and wake request
    // ****************************************************************
    wire [7:0] irq_src;
    wire       evt_any;
    wire       rst_src;
    wire       pm_any;
    wire       nxt_core_irq;
    wire       nxt_pwr_req;

    assign irq_src      = status_q & irq_en_ff;
    assign evt_any      = |irq_src;
    assign rst_src      = rst_sts_q & rst_en_ff;
    assign pm_any       = |pm_event_in;
    assign nxt_core_irq = evt_any | rst_src;
    assign nxt_pwr_req  = evt_any | pm_any;

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            core_irq <= 1'b0;
        else if (ce)
            core_irq <= nxt_core_irq;
    end

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            power_wake_request <= 1'b0;
        else if (ce)
            power_wake_request <= nxt_pwr_req;
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    wire [7:0] ctl_rd_val;
    wire [7:0] rst_rd_val;
    reg  [7:0] nxt_rdata;

    assign ctl_rd_val = {6'h00, ctl_ff};
    assign rst_rd_val = {6'h00, rst_en_ff, rst_sts_q};

    always @*
    begin
        nxt_rdata = `HES_RST_BYTE;
        if (reg_rd)
        begin
            case (1'b1)
                sel_status:
                    nxt_rdata = status_q;
                sel_irq_en:
                    nxt_rdata = irq_en_ff;
                sel_ctl:
                    nxt_rdata = ctl_rd_val;
                sel_rst:
                    nxt_rdata = rst_rd_val;
                default:
                    nxt_rdata = `HES_RST_BYTE;
            endcase
        end
    end

    always @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= `HES_RST_BYTE;
        else if (ce)
            reg_rdata <= nxt_rdata;
    end

endmodule

`default_nettype wire

// file: dv/hes_host_event_irq_props.sv
// Purpose: Port assertions of the host event block
// Assumes: ce held high
// Notes:   Bound to the block below
`default_nettype none
`include "hes_regs.vh"
module hes_host_event_irq_props #(
    parameter AW  = 24,
    parameter PMW = 4
) (
    input wire logic           core_clk,
    input wire logic           rst_n,
    input wire logic           ce,
    input wire logic           host_sw_reset,
    input wire logic           warm_reset,
    input wire logic [AW-1:0]  reg_addr,
    input wire logic [7:0]     reg_wdata,
    input wire logic           reg_wr,
    input wire logic           reg_rd,
    input wire logic [7:0]     reg_rdata,
    input wire logic           ri1_event,
    input wire logic           ri2_event,
    input wire logic           module_irq_event,
    input wire logic           ring_in,
    input wire logic [7:0]     wake_status0,
    input wire logic           wake_sts0_bit1_wr,
    input wire logic           host_reset_input,
    input wire logic [PMW-1:0] pm_event_in,
    input wire logic           core_irq,
    input wire logic           power_wake_request
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    wire logic rd_st = reg_rd && reg_addr == `HES_OFS_STATUS0 && !host_sw_reset;
    wire logic no_ev = !ri1_event && !ri2_event && !module_irq_event;

    chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    chk_rsvd_zero: assert property (
        reg_rd |=> (reg_rdata & ~`HES_IMPL_MASK) == 8'h00) else $error("reserved bit set");
    chk_evt_sets: assert property (
        !host_sw_reset ##1 !reg_wr && !host_sw_reset ##1 rd_st
        |=> reg_rdata[0] >= $past(ri1_event, 3) && reg_rdata[1] >= $past(ri2_event, 3)
            && reg_rdata[7] >= $past(module_irq_event, 3)) else $error("event lost");
    chk_w1c_clears: assert property (
        reg_wr && reg_addr == `HES_OFS_STATUS0 && reg_wdata == 8'hFF && no_ev ##1 no_ev ##1 rd_st
        |=> (reg_rdata & 8'h83) == 8'h00) else $error("clear ignored");
    chk_sticky_mod: assert property (
        rd_st ##1 reg_rdata[7] && !reg_wr && !host_sw_reset ##1 rd_st |=> reg_rdata[7])
        else $error("module bit dropped");
    chk_swrst_zero: assert property (
        host_sw_reset ##1 reg_rd && reg_addr == `HES_OFS_STATUS0 |=> reg_rdata == 8'h00)
        else $error("status kept over reset");
    chk_warm_irq: assert property (
        warm_reset |-> ##2 !core_irq) else $error("irq after warm reset");
    chk_pm_wake: assert property (
        (|pm_event_in) |=> power_wake_request) else $error("wake request missing");

    cov_irq: cover property (core_irq);
    cov_pwr: cover property (power_wake_request && !core_irq);
    cov_rd: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule
bind hes_host_event_irq hes_host_event_irq_props #(.AW(AW), .PMW(PMW)) u_props (.*);
`default_nettype wire

// file: dv/hes_wake_model.sv
// Purpose: Host wake status register beside the block
// Assumes: Set pulses shared with the block
// Notes:   Cleared only by its own clear input and by rst_n
`default_nettype none
module hes_wake_model (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       ri1,
    input  wire logic       ri2,
    input  wire logic       mi,
    input  wire logic       set6,
    input  wire logic       clr,
    output var  logic [7:0] sts_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            sts_ff <= 8'h00;
        else if (clr)
            sts_ff <= 8'h00;
        else
            sts_ff <= sts_ff | {mi, set6, 4'h0, ri2, ri1};
    end
endmodule
`default_nettype wire

// file: dv/hes_host_event_irq_bench.sv
// Purpose: Self-checking bench of the host event block
// Assumes: ce tied high
// Notes:   Table rows, then directed cases
`default_nettype none
`include "hes_regs.vh"
module hes_host_event_irq_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [23:0] a_st = `HES_OFS_STATUS0;
    localparam logic [23:0] a_en = `HES_OFS_IRQ_EN0;
    localparam logic [23:0] a_ct = `HES_OFS_WAKE_CTL1;
    logic core_clk = '0, rst_n = '0, sw = '0, warm = '0, wr = '0, rd = '0, wclr = '0;
    logic ri1 = '0, ri2 = '0, mi = '0, ring = '0, b1w = '0, hrst = '0, s6 = '0, irq, pwr;
    logic [23:0] ad = '0;
    logic [7:0] wd = '0, rdat, wsts, v;
    logic [3:0] pm = '0;
    int n_fail = 0, num_checks = 0, cyc = 0;
    logic [5:0] stim [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
    logic [7:0] want [6] = '{8'h01, 8'h02, 8'h80, 8'h08, 8'h40, 8'h00};

    hes_host_event_irq i_dut (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .host_sw_reset(sw),
        .warm_reset(warm), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
        .ri1_event(ri1), .ri2_event(ri2), .module_irq_event(mi), .ring_in(ring), .wake_status0(wsts),
        .wake_sts0_bit1_wr(b1w), .host_reset_input(hrst), .pm_event_in(pm), .core_irq(irq),
        .power_wake_request(pwr));
    hes_wake_model i_wake (.core_clk(core_clk), .rst_n(rst_n), .ri1(ri1), .ri2(ri2), .mi(mi),
        .set6(s6), .clr(wclr), .sts_ff(wsts));

    always #10 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_fail++;
            test_done;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [23:0] a, input logic [7:0] d);
        ad <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rreg(input logic [23:0] a, output logic [7:0] q);
        ad <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 q = rdat;
        @(posedge core_clk);
    endtask
    task automatic ev(input logic [5:0] s);
        {b1w, s6, ring, mi, ri2, ri1} <= s;
        @(posedge core_clk);
        {b1w, s6, mi, ri2, ri1} <= 5'h00;
        @(posedge core_clk);
    endtask
    task automatic look(input logic [1:0] exp);
        #1 chk({6'h00, pwr, irq}, {6'h00, exp});
        @(posedge core_clk);
    endtask
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rreg(a_st, v);
        chk(v, `HES_RST_STATUS0);
        rreg(a_en, v);
        chk(v, `HES_RST_IRQ_EN0);
        rreg(24'h00FCE0, v);
        chk(v, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            ev(stim[i]);
            rreg(a_st, v);
            chk(v, want[i]);
            wreg(a_st, 8'hFF);
            rreg(a_st, v);
            chk(v, 8'h00);
        end
        wreg(a_ct, 8'h01);
        ev(6'h20);
        rreg(a_st, v);
        chk(v, 8'h40);
        wreg(a_ct, 8'h02);
        ev(6'h08);
        ev(6'h00);
        rreg(a_st, v);
        chk(v, 8'h48);
        wreg(a_st, 8'hFF);
        ev(6'h04);
        wclr <= 1'b1;
        @(posedge core_clk);
        wclr <= 1'b0;
        repeat (4) @(posedge core_clk);
        rreg(a_st, v);
        chk(v, 8'h80);
        rreg(a_st, v);
        chk(v, 8'h80);
        wreg(a_en, 8'hFF);
        rreg(a_en, v);
        chk(v, 8'hCB);
        look(2'b11);
        wreg(a_en, 8'h00);
        look(2'b00);
        wreg(a_en, 8'h80);
        look(2'b11);
        wreg(a_st, 8'h80);
        look(2'b00);
        ad <= a_st;
        wd <= 8'hFF;
        wr <= 1'b1;
        ri1 <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        ri1 <= 1'b0;
        @(posedge core_clk);
        rreg(a_st, v);
        chk(v, 8'h01);
        sw <= 1'b1;
        @(posedge core_clk);
        sw <= 1'b0;
        rreg(a_st, v);
        chk(v, 8'h00);
        wreg(`HES_OFS_RST_EVT, 8'h02);
        hrst <= 1'b1;
        @(posedge core_clk);
        hrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        look(2'b01);
        warm <= 1'b1;
        @(posedge core_clk);
        warm <= 1'b0;
        @(posedge core_clk);
        look(2'b00);
        pm <= 4'h8;
        @(posedge core_clk);
        look(2'b10);
        pm <= 4'h0;
        wreg(a_en, 8'h01);
        ev(6'h01);
        look(2'b11);
        rst_n <= 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        look(2'b00);
        rreg(a_st, v);
        chk(v, `HES_RST_STATUS0);
        rreg(a_en, v);
        chk(v, `HES_RST_IRQ_EN0);
        test_done;
    end
endmodule
`default_nettype wire
